// >>> rtl/dgp_pkg.sv
/*
 * dgp_pkg: register map, field layout and reset values for the dual gpio port pair.
 * assumes a classic wishbone slave with 32-bit data, one register per aligned word.
 */
package dgp_pkg;
    localparam int unsigned DGP_ADDR_W = 5;
    localparam int unsigned DGP_DATA_W = 32;
    // byte offsets of the registers
    localparam logic [4:0] DGP_OFF_F_DATA = 5'h00;
    localparam logic [4:0] DGP_OFF_F_DIR  = 5'h04;
    localparam logic [4:0] DGP_OFF_G_DATA = 5'h08;
    localparam logic [4:0] DGP_OFF_G_DIR  = 5'h0c;
    localparam logic [4:0] DGP_OFF_G_PULL = 5'h10;
    // implemented bit masks of each port
    localparam logic [7:0] DGP_F_MASK  = 8'h07;
    localparam logic [7:0] DGP_G_MASK  = 8'h06;
    // open-drain pins of the first port (none by default)
    localparam logic [7:0] DGP_F_OD    = 8'h00;
    // reset values
    localparam logic [7:0] DGP_RST_LATCH = 8'h00;
    localparam logic [7:0] DGP_RST_DIR   = 8'h00;
    localparam logic [7:0] DGP_RST_PULL  = 8'h00;
    // bus access state
    typedef enum logic [0:0] {
        DGP_IDLE = 1'b0,
        DGP_ACK  = 1'b1
    } dgp_bus_type;
endpackage

// >>> rtl/dgp_pin_cell.sv
/*
 * dgp_pin_cell: one pad's output, enable, pull-up and input-clamp logic.
 * assumes inputs are synchronous to the clock; the pad itself resolves the wire.
 */
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_cell #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic latch_in,     // output latch bit
    input  wire logic dir_in,       // 1 = output
    input  wire logic pull_in,      // pull-up bit
    input  wire logic per_en_in,    // peripheral output enable
    input  wire logic per_val_in,   // peripheral output value
    input  wire logic hiz_in,       // standby force hi-z
    input  wire logic pad_in,       // pad level
    output logic      out_d_out,    // next pad value
    output logic      oe_d_out,     // next pad enable
    output logic      pull_d_out,   // next pull-up connect
    output logic      in_out        // clamped input level
);
    logic drv_val;
    logic drv_en;

    // peripheral wins over the port; open drain never drives high
    always_comb begin
        drv_val = per_en_in ? per_val_in : latch_in;
        drv_en  = per_en_in | dir_in;
        if (OPEN_DRAIN && drv_val) begin
            drv_en = 1'b0;
        end
        out_d_out  = drv_val;
        oe_d_out   = drv_en & ~hiz_in;
        pull_d_out = pull_in & ~hiz_in & ~(oe_d_out & ~drv_val);
        in_out     = hiz_in ? 1'b0 : pad_in;
    end
endmodule
`default_nettype wire

// >>> rtl/dgp_port_pair.sv
/*
 * dgp_port_pair: two small gpio ports behind a classic wishbone slave.
 * assumes one clock, synchronous pad inputs and a standby controller
 * that supplies the pin-state bit and the stop/watch indication.
 */
`timescale 1ns/1ps
`default_nettype none
module dgp_port_pair
    import dgp_pkg::*;
#(
    parameter int unsigned PORT_W = 8
) (
    input  wire logic                  clk_in,        // 10 MHz clock
    input  wire logic                  rstn_in,       // async reset, active low
    input  wire logic                  wb_cyc_in,     // wishbone cycle
    input  wire logic                  wb_stb_in,     // wishbone strobe
    input  wire logic                  wb_we_in,      // wishbone write
    input  wire logic [dgp_pkg::DGP_ADDR_W-1:0] wb_adr_in, // byte address
    input  wire logic [3:0]            wb_sel_in,     // byte selects
    input  wire logic [31:0]           wb_dat_in,     // write data
    input  wire logic                  rmw_in,        // read is read-modify-write
    output logic      [31:0]           wb_dat_out,    // read data
    output logic                       wb_ack_out,    // wishbone ack
    output logic                       wb_err_out,    // unmapped address
    input  wire logic                  spl_bit_in,    // standby pin-state bit
    input  wire logic                  stop_watch_in, // stop or watch mode active
    input  wire logic [PORT_W-1:0]     f_pad_in,      // first port pad levels
    output logic      [PORT_W-1:0]     f_pad_out,     // first port pad values
    output logic      [PORT_W-1:0]     f_pad_oe_out,  // first port pad enables
    input  wire logic [PORT_W-1:0]     g_pad_in,      // second port pad levels
    output logic      [PORT_W-1:0]     g_pad_out,     // second port pad values
    output logic      [PORT_W-1:0]     g_pad_oe_out,  // second port pad enables
    output logic      [PORT_W-1:0]     g_pull_out,    // second port pull-up connect
    input  wire logic [PORT_W-1:0]     g_per_en_in,   // peripheral output enables
    input  wire logic [PORT_W-1:0]     g_per_val_in,  // peripheral output values
    output logic      [PORT_W-1:0]     f_in_out,      // clamped inputs to peripherals
    output logic      [PORT_W-1:0]     g_in_out       // clamped inputs to peripherals
);
    import dgp_pkg::*;

    // masks, latches and the read path are eight bits wide; refuse anything else
    if (PORT_W != 8) begin : g_bad_width
        $error("dgp_port_pair supports PORT_W of 8 only");
    end

    logic [7:0]  f_latch_q, f_dir_q, g_latch_q, g_dir_q, g_pull_q;
    logic [7:0]  f_out_d, f_oe_d, f_in_d, g_out_d, g_oe_d, g_pull_d, g_in_d;
    logic [7:0]  f_read, g_read;
    logic        hiz;
    logic        req;
    logic        wr_en;
    dgp_bus_type bus_q;

    // standby forces hi-z only when the pin-state bit is set
    assign hiz = spl_bit_in & stop_watch_in;

    // one request per cycle; ack drops the cycle after it was given
    assign req   = wb_cyc_in & wb_stb_in & (bus_q == DGP_IDLE);
    assign wr_en = req & wb_we_in & wb_sel_in[0];

    // address decode shared by ack and error logic
    function automatic logic mapped(input logic [4:0] a);
        case (a)
            DGP_OFF_F_DATA, DGP_OFF_F_DIR, DGP_OFF_G_DATA,
            DGP_OFF_G_DIR, DGP_OFF_G_PULL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // per-pin cells; unused bit positions are tied off by the masks
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            dgp_pin_cell #(.OPEN_DRAIN(DGP_F_OD[i])) u_f (
                .latch_in   (f_latch_q[i]),
                .dir_in     (f_dir_q[i]),
                .pull_in    (1'b0),
                .per_en_in  (1'b0),
                .per_val_in (1'b0),
                .hiz_in     (hiz),
                .pad_in     (f_pad_in[i]),
                .out_d_out  (f_out_d[i]),
                .oe_d_out   (f_oe_d[i]),
                .pull_d_out (),
                .in_out     (f_in_d[i])
            );
            dgp_pin_cell #(.OPEN_DRAIN(1'b0)) u_g (
                .latch_in   (g_latch_q[i]),
                .dir_in     (g_dir_q[i]),
                .pull_in    (g_pull_q[i]),
                .per_en_in  (g_per_en_in[i] & DGP_G_MASK[i]),
                .per_val_in (g_per_val_in[i]),
                .hiz_in     (hiz),
                .pad_in     (g_pad_in[i]),
                .out_d_out  (g_out_d[i]),
                .oe_d_out   (g_oe_d[i]),
                .pull_d_out (g_pull_d[i]),
                .in_out     (g_in_d[i])
            );
        end
    endgenerate

    // pad outputs registered so every output comes from a flip-flop
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            f_pad_out    <= 8'h00;
            f_pad_oe_out <= 8'h00;
            g_pad_out    <= 8'h00;
            g_pad_oe_out <= 8'h00;
            g_pull_out   <= 8'h00;
            f_in_out     <= 8'h00;
            g_in_out     <= 8'h00;
        end else begin
            f_pad_out    <= f_out_d & DGP_F_MASK;
            f_pad_oe_out <= f_oe_d & DGP_F_MASK;
            g_pad_out    <= g_out_d & DGP_G_MASK;
            g_pad_oe_out <= g_oe_d & DGP_G_MASK;
            g_pull_out   <= g_pull_d & DGP_G_MASK;
            f_in_out     <= f_in_d & DGP_F_MASK;
            g_in_out     <= g_in_d & DGP_G_MASK;
        end
    end

    // latches always take writes; the pin cell decides who sees them
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            f_latch_q <= DGP_RST_LATCH;
            g_latch_q <= DGP_RST_LATCH;
        end else if (wr_en) begin
            if (wb_adr_in == DGP_OFF_F_DATA) begin
                f_latch_q <= wb_dat_in[7:0] & DGP_F_MASK;
            end
            if (wb_adr_in == DGP_OFF_G_DATA) begin
                g_latch_q <= wb_dat_in[7:0] & DGP_G_MASK;
            end
        end
    end

    // direction bits clear at reset so every pin starts as input
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            f_dir_q <= DGP_RST_DIR;
            g_dir_q <= DGP_RST_DIR;
        end else if (wr_en) begin
            if (wb_adr_in == DGP_OFF_F_DIR) begin
                f_dir_q <= wb_dat_in[7:0] & DGP_F_MASK;
            end
            if (wb_adr_in == DGP_OFF_G_DIR) begin
                g_dir_q <= wb_dat_in[7:0] & DGP_G_MASK;
            end
        end
    end

    // pull-up enables of the second port
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            g_pull_q <= DGP_RST_PULL;
        end else if (wr_en && wb_adr_in == DGP_OFF_G_PULL) begin
            g_pull_q <= wb_dat_in[7:0] & DGP_G_MASK;
        end
    end

    // data reads: latch on rmw or for port-driven outputs, else the pad.
    // the pad is taken after the clamp, so hi-z standby reads low.
    always_comb begin
        f_read = rmw_in ? f_latch_q
                        : ((f_latch_q & f_dir_q) | (f_in_d & ~f_dir_q));
        g_read = rmw_in ? g_latch_q
                        : ((g_latch_q & g_dir_q & ~g_per_en_in)
                           | (g_in_d & ~(g_dir_q & ~g_per_en_in)));
        f_read = f_read & DGP_F_MASK;
        g_read = g_read & DGP_G_MASK;
    end

    // wishbone answer: ack or err one cycle after the request, then idle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_q      <= DGP_IDLE;
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else if (req) begin
            bus_q      <= DGP_ACK;
            wb_ack_out <= mapped(wb_adr_in);
            wb_err_out <= ~mapped(wb_adr_in);
            case (wb_adr_in)
                DGP_OFF_F_DATA: wb_dat_out <= {24'h00_0000, f_read};
                DGP_OFF_F_DIR:  wb_dat_out <= {24'h00_0000, f_dir_q};
                DGP_OFF_G_DATA: wb_dat_out <= {24'h00_0000, g_read};
                DGP_OFF_G_DIR:  wb_dat_out <= {24'h00_0000, g_dir_q};
                DGP_OFF_G_PULL: wb_dat_out <= {24'h00_0000, g_pull_q};
                default:        wb_dat_out <= 32'h0000_0000;
            endcase
        end else begin
            bus_q      <= DGP_IDLE;
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
        end
    end

    // standby with pin-state set: no pin driven, clamped inputs low
    a_standby_hiz: assert property (@(posedge clk_in) disable iff (!rstn_in)
        hiz |=> (f_pad_oe_out == 8'h00 && g_pad_oe_out == 8'h00
                 && f_in_out == 8'h00 && g_in_out == 8'h00))
        else $error("pins not released in standby");

    a_standby_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!hiz && f_dir_q[0]) |=> f_pad_oe_out[0])
        else $error("output dropped without pin-state bit");

    a_output_value: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (f_dir_q[1] && !hiz) |=> (f_pad_oe_out[1] && f_pad_out[1] == $past(f_latch_q[1])))
        else $error("first port output differs from latch");

    a_input_float: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!f_dir_q[2]) |=> !f_pad_oe_out[2])
        else $error("input pin driven");

    a_unused_bits: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ((f_dir_q & ~DGP_F_MASK) == 8'h00 && (g_dir_q & ~DGP_G_MASK) == 8'h00
         && g_pad_oe_out[0] == 1'b0))
        else $error("unused bit implemented");

    a_pull_low_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (g_pad_oe_out[1] && !g_pad_out[1]) |-> !g_pull_out[1])
        else $error("pull-up on while driving low");

    a_periph_drive: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (g_per_en_in[2] && !hiz) |=> (g_pad_oe_out[2] && g_pad_out[2] == $past(g_per_val_in[2])))
        else $error("peripheral not driving second port");

    sequence s_rmw_read;
        req && !wb_we_in && rmw_in && wb_adr_in == DGP_OFF_G_DATA;
    endsequence
    a_rmw_latch: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_rmw_read |=> (wb_ack_out && wb_dat_out[7:0] == $past(g_latch_q)))
        else $error("rmw read not returning latch");

    a_ack_one: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// >>> verif/dgp_board_pins.sv
/*
 * dgp_board_pins: board side of one eight-pin port, resolving each pad level.
 * assumes the bench never drives a pin while the port drives it.
 */
`timescale 1ns/1ps
`default_nettype none
module dgp_board_pins (
    input  wire logic       clk_in,     // system clock
    input  wire logic [7:0] pad_out_in, // port pad values
    input  wire logic [7:0] pad_oe_in,  // port pad enables
    input  wire logic [7:0] pull_in,    // pull-up connect
    input  wire logic [7:0] ext_val_in, // board drive values
    input  wire logic [7:0] ext_oe_in,  // board drive enables
    output logic      [7:0] level_out   // resolved pad levels
);
    logic [7:0] float_q = 8'h00; // defined start, else the toggle stays unknown
    // a floating line toggles so that a read of it can never match by luck
    always_ff @(posedge clk_in) begin
        float_q <= ~level_out;
    end
    // board driver first, then the port, then the pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_oe_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pad_oe_in[i]) begin
                level_out[i] = pad_out_in[i];
            end else if (pull_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_dual_gpio_port_pair.sv
/*
 * tb_dual_gpio_port_pair: self-checking bench for the two gpio ports.
 * assumes a one-cycle wishbone answer and one-clock lag on all pin outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_gpio_port_pair;
    import dgp_pkg::*;
    typedef struct packed {logic [4:0] adr; logic [7:0] wd; logic [7:0] ex;} dgp_row_type;
    logic        clk_in = 1'b0, rstn_in = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic        rmw = 1'b0, standby_pin_state_bit = 1'b0, stop = 1'b0, wb_ack, wb_err, last_err;
    logic [4:0]  wb_adr = 5'h00;
    logic [3:0]  wb_sel = 4'h1;
    logic [31:0] wb_dat = 32'h0, wb_rdat;
    logic [7:0]  f_ev = 8'h00, f_eo = 8'h00, g_ev = 8'h00, g_eo = 8'h00, pen = 8'h00;
    logic [7:0]  pval = 8'h00, f_lvl, g_lvl, f_po, f_oe, g_po, g_oe, g_pu, f_in, g_in, q;
    int          num_errors = 0, checks = 0;
    // register rows: written value and the masked value read back
    dgp_row_type rows [6] = '{'{DGP_OFF_F_DIR, 8'hff, 8'h07}, '{DGP_OFF_G_DIR, 8'hff, 8'h06},
        '{DGP_OFF_G_PULL, 8'hff, 8'h06}, '{DGP_OFF_F_DIR, 8'h00, 8'h00},
        '{DGP_OFF_G_DIR, 8'h00, 8'h00}, '{DGP_OFF_G_PULL, 8'h00, 8'h00}};

    dgp_port_pair u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
        .wb_dat_in(wb_dat), .rmw_in(rmw), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
        .wb_err_out(wb_err), .spl_bit_in(standby_pin_state_bit), .stop_watch_in(stop),
        .f_pad_in(f_lvl), .f_pad_out(f_po), .f_pad_oe_out(f_oe), .g_pad_in(g_lvl),
        .g_pad_out(g_po), .g_pad_oe_out(g_oe), .g_pull_out(g_pu), .g_per_en_in(pen),
        .g_per_val_in(pval), .f_in_out(f_in), .g_in_out(g_in));
    dgp_board_pins u_fb (.clk_in(clk_in), .pad_out_in(f_po), .pad_oe_in(f_oe),
        .pull_in(8'h00), .ext_val_in(f_ev), .ext_oe_in(f_eo), .level_out(f_lvl));
    dgp_board_pins u_gb (.clk_in(clk_in), .pad_out_in(g_po), .pad_oe_in(g_oe),
        .pull_in(g_pu), .ext_val_in(g_ev), .ext_oe_in(g_eo), .level_out(g_lvl));

    initial begin
        forever #50 clk_in = ~clk_in;
    end
    // compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // one classic cycle; the idle edge at entry keeps a gap between requests
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d, input logic r);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= {24'h0, d};
        rmw    <= r;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 20);
        q = wb_rdat[7:0];
        last_err = wb_err;
        if (n >= 20) chk(8'h00, 8'h01, "no bus answer");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        rmw    <= 1'b0;
    endtask
    // pin outputs lag by one clock; give them room and sample off the edge
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a hang is cut off well past the roughly 130 cycles the run needs
    initial begin
        #(3000 * 100);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        chk(f_oe | g_oe, 8'h00, "reset enables");
        wb(1'b0, DGP_OFF_F_DIR, 8'h00, 1'b0);
        chk(q, 8'h00, "f dir reset");
        wb(1'b0, DGP_OFF_G_DIR, 8'h00, 1'b0);
        chk(q, 8'h00, "g dir reset");
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wd, 1'b0);
            wb(1'b0, rows[i].adr, 8'h00, 1'b0);
            chk(q, rows[i].ex, "register row");
        end
        // first port as output
        wb(1'b1, DGP_OFF_F_DIR, 8'h07, 1'b0);
        wb(1'b1, DGP_OFF_F_DATA, 8'hfd, 1'b0);
        settle();
        chk(f_oe, 8'h07, "f enables");
        chk(f_po, 8'h05, "f values");
        wb(1'b0, DGP_OFF_F_DATA, 8'h00, 1'b0);
        chk(q, 8'h05, "f output read");
        // first port as input, latch written while the board drives
        wb(1'b1, DGP_OFF_F_DIR, 8'h00, 1'b0);
        f_ev <= 8'h02;
        f_eo <= 8'h07;
        wb(1'b1, DGP_OFF_F_DATA, 8'h06, 1'b0);
        settle();
        chk(f_oe, 8'h00, "f input enables");
        chk(f_in, 8'h02, "f clamped input");
        wb(1'b0, DGP_OFF_F_DATA, 8'h00, 1'b0);
        chk(q, 8'h02, "f pad read");
        wb(1'b0, DGP_OFF_F_DATA, 8'h00, 1'b1);
        chk(q, 8'h06, "f rmw read");
        f_eo <= 8'h00;
        wb(1'b1, DGP_OFF_F_DIR, 8'h07, 1'b0);
        settle();
        chk(f_po, 8'h06, "f stored latch");
        // second port with pull-ups: low pin must drop its pull-up
        wb(1'b1, DGP_OFF_G_PULL, 8'h06, 1'b0);
        wb(1'b1, DGP_OFF_G_DATA, 8'h02, 1'b0);
        settle();
        chk(g_pu, 8'h06, "g pull inputs");
        wb(1'b0, DGP_OFF_G_DATA, 8'h00, 1'b0);
        chk(q, 8'h06, "g pulled read");
        wb(1'b1, DGP_OFF_G_DIR, 8'h06, 1'b0);
        settle();
        chk(g_oe, 8'h06, "g enables");
        chk(g_po, 8'h02, "g values");
        chk(g_pu, 8'h02, "g pull low pin");
        // peripheral takes pin two
        @(posedge clk_in);
        pen  <= 8'h04;
        pval <= 8'h04;
        settle();
        chk(g_po, 8'h06, "g peripheral value");
        wb(1'b0, DGP_OFF_G_DATA, 8'h00, 1'b0);
        chk(q, 8'h06, "g peripheral read");
        wb(1'b0, DGP_OFF_G_DATA, 8'h00, 1'b1);
        chk(q, 8'h02, "g peripheral rmw");
        pen <= 8'h00;
        // standby with the pin-state bit clear keeps the pins
        stop <= 1'b1;
        settle();
        chk(f_oe | g_oe, 8'h07, "hold enables");
        chk(f_po | g_po, 8'h06, "hold values");
        @(posedge clk_in);
        standby_pin_state_bit <= 1'b1;
        settle();
        chk(f_oe | g_oe, 8'h00, "standby enables");
        chk(f_in | g_in, 8'h00, "standby inputs");
        @(posedge clk_in);
        stop <= 1'b0;
        standby_pin_state_bit  <= 1'b0;
        // unmapped address is refused and stores nothing
        wb(1'b1, 5'h14, 8'hff, 1'b0);
        chk({7'h0, last_err}, 8'h01, "unmapped error");
        // a write without its low byte select is acked but stores nothing
        wb_sel <= 4'h0;
        wb(1'b1, DGP_OFF_G_PULL, 8'h00, 1'b0);
        wb_sel <= 4'h1;
        wb(1'b0, DGP_OFF_G_PULL, 8'h00, 1'b0);
        chk(q, 8'h06, "pull after refusal");
        wrap_up();
    end
endmodule
`default_nettype wire
